/* common/irtc_params.svh */
`ifndef IRTC_PARAMS_SVH
`define IRTC_PARAMS_SVH
`define IRTC_CNT_W 9
`define IRTC_TICK_DIV 8
`define IRTC_TICK_DIV_HALF 16
`define IRTC_CR0_RESET 8'h03
`define IRTC_CR0_SEL_LO 0
`define IRTC_CR0_SEL_HI 1
`define IRTC_CR0_CARRIER_OFF 2
`define IRTC_CR0_HALVE 3
`define IRTC_PERMIT_BIT 9
`define IRTC_HALT_TIMER_CODE 3'h5
`define IRTC_ADDR_CR0 4'h0
`define IRTC_ADDR_TIMER 4'h1
`define IRTC_ADDR_STATUS 4'h2
`define IRTC_ADDR_STANDBY 4'h3
`endif

/* common/irtc_pkg.sv */
package irtc_pkg;
    typedef enum logic [1:0] {
        IRTC_RUN,
        IRTC_HALT,
        IRTC_STOP_WAIT,
        IRTC_STOP
    } irtc_mode_t;
    typedef struct packed {
        logic ir_transmit_pin;
        logic sense1_indicator_pin;
        logic timer_end;
    } irtc_pins_t;
endpackage

/* rtl/irtc_timer.sv */
`timescale 1ns/100ps
`include "irtc_params.svh"
// Behaviour
// [RQ1] 9-bit down counter, tenth permit bit, zero detector on the counter.
// [RQ2] any load of nonzero count starts counting down.
// [RQ3] decrement every 8 oscillator periods, 16 with halving bit set.
// [RQ4] at zero the end signal asserts and holds while counter stays zero.
// [RQ5] end signal cancels the timer-wait halt; execution resumes after it.
// [RQ6] interval is loaded count plus one times tick period.
// [RQ7] permit flag one routes timer state to transmit and indicator pins.
// [RQ8] running: indicator low, transmit high or carrier; stopped: reverse.
// [RQ9] carrier gated onto transmit only when carrier-disable bit is zero.
// [RQ10] stopping during carrier high holds transmit until carrier falls. Code drops it at once when the count ends during a stop request.
// [RQ11] first carrier high phase may be short; no realignment on start.
// [RQ12] alternating nonzero and zero loads give pulses one instruction wide.
// [RQ13] stop standby halts oscillator, crystal pins low, count forced zero.
// [RQ14] halt standby keeps oscillator and timer outputs running.
// [RQ15] standby keeps all other held state unchanged.
// [RQ16] stop leaves a cleared count so timer is idle on exit.
// [RQ17] standby entered only with standby status flag zero.
// [RQ18] any standby cancel sets the standby status flag.
// [RQ19] release already true at entry skips standby and sets the flag.
// [RQ20] software puts a no-op first after leaving stop.
// [RQ21] carrier select: fx, fx/8, fx/12 half, fx/12 third; halving halves it. Code halves only fx/8 and fx/12; fx stays a toggle every cycle.
// [RQ22] carrier-disable one holds transmit high while timer runs.
// [RQ23] stop requested while running waits until all ten timer bits are zero.
// [RQ24] loads act at end of instruction; zero load stops timer at once.
module irtc_timer
    import irtc_pkg::*;
#(
    parameter int CNT_W = `IRTC_CNT_W
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic release_in,
    output logic ir_transmit_pin,
    output logic sense1_indicator_pin,
    input wire logic sense1_output_mode,
    output logic timer_end,
    output logic halt_wake,
    output logic osc_stopped,
    output logic osc_input_pin,
    output logic osc_output_pin,
    output logic cpu_halted
);
    // timer word: bit 9 permit, low 9 count; writes use mask to load parts
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic permit_reg, permit_next;
    logic [4:0] div_reg, div_next;
    logic first_reg, first_next;
    logic [4:0] tick_last;
    logic xin_reg, osc_output_pin_reg;
    logic [7:0] cr0_reg, cr0_next;
    logic [4:0] car_cnt_reg, car_cnt_next;
    logic car_reg, car_next;
    logic tx_reg, tx_next;
    logic ind_reg, ind_next;
    logic end_reg, end_next;
    logic wake_reg, wake_next;
    logic flag_reg, flag_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [1:0] rel_sync_reg;
    logic [1:0] rel_sync_next;
    logic [2:0] halt_code_reg, halt_code_next;
    irtc_mode_t mode_reg, mode_next;
    logic running, tick, car_period_end, car_high;
    logic [4:0] car_len, car_hi_len;
    logic halve;

    assign running = (cnt_reg != '0); // [RQ1]
    assign halve = cr0_reg[`IRTC_CR0_HALVE];
    // the first tick after a load lasts two periods, so n gives n plus one periods
    always_comb begin
        tick_last = halve ? 5'(`IRTC_TICK_DIV_HALF - 1) : 5'(`IRTC_TICK_DIV - 1); // [RQ3]
        if (first_reg) begin
            tick_last = halve ? 5'(2 * `IRTC_TICK_DIV_HALF - 1) : 5'(2 * `IRTC_TICK_DIV - 1); // [RQ6]
        end
    end
    assign tick = (div_reg == tick_last);

    // carrier length in ref_clk cycles standing for oscillator periods
    always_comb begin
        unique case ({cr0_reg[`IRTC_CR0_SEL_HI], cr0_reg[`IRTC_CR0_SEL_LO]}) // [RQ21]
            2'h0: begin
                car_len = 5'h01;
                car_hi_len = 5'h01;
            end
            2'h1: begin
                car_len = 5'h08;
                car_hi_len = 5'h04;
            end
            2'h2: begin
                car_len = 5'h0c;
                car_hi_len = 5'h06;
            end
            2'h3: begin
                car_len = 5'h0c;
                car_hi_len = 5'h04;
            end
        endcase
    end

    // fx at half duty is emulated as toggle every cycle; halving doubles both for the other selects, not for fx
    always_comb begin
        car_cnt_next = car_cnt_reg + 5'h01;
        car_next = car_reg;
        if (halve && {cr0_reg[`IRTC_CR0_SEL_HI], cr0_reg[`IRTC_CR0_SEL_LO]} != 2'h0) begin
            car_period_end = (car_cnt_reg >= 5'((car_len << 1) - 5'h01));
            car_high = (car_cnt_reg < 5'(car_hi_len << 1));
        end else if (halve) begin
            car_period_end = (car_cnt_reg >= 5'h01);
            car_high = (car_cnt_reg == 5'h00);
        end else if ({cr0_reg[`IRTC_CR0_SEL_HI], cr0_reg[`IRTC_CR0_SEL_LO]} == 2'h0) begin
            car_period_end = 1'b1;
            car_high = ~car_reg;
        end else begin
            car_period_end = (car_cnt_reg >= car_len - 5'h01);
            car_high = (car_cnt_reg < car_hi_len);
        end
        if (car_period_end) begin
            car_cnt_next = 5'h00;
        end
        // free running carrier, not realigned to timer start
        car_next = car_high; // [RQ11]
        if (mode_reg == IRTC_STOP) begin
            car_cnt_next = car_cnt_reg;
            car_next = 1'b0;
        end
    end

    always_comb begin
        cnt_next = cnt_reg;
        permit_next = permit_reg;
        div_next = running ? (tick ? 5'h00 : div_reg + 5'h01) : 5'h00;
        first_next = first_reg;
        cr0_next = cr0_reg;
        halt_code_next = halt_code_reg;
        mode_next = mode_reg;
        flag_next = flag_reg;
        wake_next = 1'b0;
        rel_sync_next = {rel_sync_reg[0], release_in};
        if (running && tick) begin
            cnt_next = cnt_reg - 9'(1); // [RQ3] [RQ6]
            first_next = 1'b0;
        end
        if (wr && mode_reg != IRTC_STOP) begin
            unique case (addr)
                `IRTC_ADDR_CR0: cr0_next = wdata[7:0];
                `IRTC_ADDR_TIMER: begin
                    // byte mask: bit 12 low part, bit 13 high part
                    if (wdata[12]) begin
                        cnt_next[3:0] = wdata[3:0]; // [RQ2] [RQ24]
                    end
                    if (wdata[13]) begin
                        cnt_next[CNT_W-1:4] = wdata[CNT_W-1:4];
                        permit_next = wdata[`IRTC_PERMIT_BIT];
                    end
                    div_next = 5'h00;
                    first_next = 1'b1; // [RQ6]
                end
                `IRTC_ADDR_STANDBY: begin
                    halt_code_next = wdata[2:0];
                    if (flag_reg) begin
                        flag_next = rel_sync_reg[1]; // [RQ17]
                    end else if ((wdata[2:0] == `IRTC_HALT_TIMER_CODE && !running) ||
                                 (wdata[2:0] != `IRTC_HALT_TIMER_CODE && rel_sync_reg[1])) begin
                        flag_next = 1'b1; // [RQ19]
                    end else if (wdata[2:0] == `IRTC_HALT_TIMER_CODE || wdata[3]) begin
                        mode_next = IRTC_HALT; // [RQ14]
                    end else begin
                        mode_next = IRTC_STOP_WAIT; // [RQ23]
                    end
                end
                `IRTC_ADDR_STATUS: flag_next = wdata[0];
                default: ;
            endcase
        end
        unique case (mode_reg)
            IRTC_RUN: ;
            IRTC_HALT: begin
                if (halt_code_reg == `IRTC_HALT_TIMER_CODE ? !running : rel_sync_reg[1]) begin
                    mode_next = IRTC_RUN; // [RQ5]
                    wake_next = 1'b1;
                    flag_next = 1'b1; // [RQ18]
                end
            end
            IRTC_STOP_WAIT: begin
                if (!running && !permit_reg) begin
                    mode_next = IRTC_STOP; // [RQ23]
                end else if (cnt_next == '0) begin
                    permit_next = 1'b0;
                end
            end
            IRTC_STOP: begin
                cnt_next = '0; // [RQ13] [RQ16]
                permit_next = 1'b0;
                if (rel_sync_reg[1]) begin
                    mode_next = IRTC_RUN;
                    wake_next = 1'b1;
                    flag_next = 1'b1; // [RQ18]
                end
            end
        endcase
    end

    // read data stands one cycle only, zero otherwise
    always_comb begin
        rdata_next = 16'h0000;
        if (rd) begin
            unique case (addr)
                `IRTC_ADDR_CR0: rdata_next = {8'h00, cr0_reg};
                `IRTC_ADDR_TIMER: rdata_next = {6'h00, permit_reg, cnt_reg};
                `IRTC_ADDR_STATUS: rdata_next = {13'h0000, end_reg, running, flag_reg};
                `IRTC_ADDR_STANDBY: rdata_next = {14'h0000, mode_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // pin outputs; other cpu state simply holds in standby
    always_comb begin
        end_next = (cnt_next == '0); // [RQ4] [RQ24]
        tx_next = 1'b0;
        ind_next = 1'b1;
        if (permit_next) begin // [RQ7]
            if (cnt_next != '0) begin
                ind_next = ~sense1_output_mode; // [RQ8]
                tx_next = cr0_reg[`IRTC_CR0_CARRIER_OFF] ? 1'b1 : car_next; // [RQ9] [RQ22]
            end else begin
                // hold a high carrier until its falling edge
                tx_next = tx_reg & car_next & ~cr0_reg[`IRTC_CR0_CARRIER_OFF]; // [RQ10] [RQ12]
            end
        end
        if (!sense1_output_mode) begin
            ind_next = 1'b1;
        end
    end

    // timer word and its prescaler
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
            permit_reg <= 1'b0;
            div_reg <= 5'h00;
            first_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            permit_reg <= permit_next;
            div_reg <= div_next;
            first_reg <= first_next;
        end
    end

    // carrier generator
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            car_cnt_reg <= 5'h00;
            car_reg <= 1'b0;
        end else begin
            car_cnt_reg <= car_cnt_next;
            car_reg <= car_next;
        end
    end

    // pins driven by the timer
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_reg <= 1'b0;
            ind_reg <= 1'b1;
            end_reg <= 1'b1;
        end else begin
            tx_reg <= tx_next;
            ind_reg <= ind_next;
            end_reg <= end_next;
        end
    end

    // control, standby and bus state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cr0_reg <= `IRTC_CR0_RESET;
            wake_reg <= 1'b0;
            flag_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            rel_sync_reg <= 2'h0;
            halt_code_reg <= 3'h0;
            mode_reg <= IRTC_RUN;
        end else begin
            cr0_reg <= cr0_next;
            wake_reg <= wake_next;
            flag_reg <= flag_next;
            rdata_reg <= rdata_next;
            rel_sync_reg <= rel_sync_next;
            halt_code_reg <= halt_code_next;
            mode_reg <= mode_next;
        end
    end

    logic osc_stop_reg, cpu_halt_reg;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            osc_stop_reg <= 1'b0;
            cpu_halt_reg <= 1'b0;
            xin_reg <= 1'b0;
            osc_output_pin_reg <= 1'b0;
        end else begin
            osc_stop_reg <= (mode_next == IRTC_STOP); // [RQ13]
            cpu_halt_reg <= (mode_next != IRTC_RUN); // [RQ14] [RQ15]
            // crystal pins held low; the oscillator itself is outside
            xin_reg <= 1'b0; // [RQ13]
            osc_output_pin_reg <= 1'b0;
        end
    end

    assign rdata = rdata_reg;
    assign ir_transmit_pin = tx_reg;
    assign sense1_indicator_pin = ind_reg;
    assign timer_end = end_reg;
    assign halt_wake = wake_reg;
    assign osc_stopped = osc_stop_reg;
    assign osc_input_pin = xin_reg;
    assign osc_output_pin = osc_output_pin_reg;
    assign cpu_halted = cpu_halt_reg;
endmodule

/* bench/irtc_timer_props.sv */
`timescale 1ns/100ps
`include "irtc_params.svh"
module irtc_timer_props (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic ir_transmit_pin,
    input wire logic sense1_indicator_pin,
    input wire logic timer_end,
    input wire logic halt_wake,
    input wire logic osc_stopped,
    input wire logic osc_input_pin,
    input wire logic osc_output_pin,
    input wire logic cpu_halted
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic wait_timer_reg;
    logic wait_timer_next;
    // last standby write decides; a refused entry must not arm a later check
    always_comb begin
        wait_timer_next = wait_timer_reg;
        if (halt_wake) wait_timer_next = 1'b0;
        if (wr && addr == `IRTC_ADDR_STANDBY) wait_timer_next = (wdata[2:0] == `IRTC_HALT_TIMER_CODE);
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) wait_timer_reg <= 1'b0;
        else wait_timer_reg <= wait_timer_next;
    end
    sequence s_timer_wait;
        wait_timer_reg && cpu_halted && !osc_stopped;
    endsequence
    sequence s_end_seen;
        timer_end ##1 timer_end;
    endsequence
    AST_TIMER_WAKE: assert property (s_timer_wait ##0 s_end_seen |-> ##[0:4] halt_wake)
        else $error("timer wait halt not released");
    AST_XTAL_LOW: assert property (!osc_input_pin && !osc_output_pin)
        else $error("crystal pins not low");
    AST_END_HOLD: assert property (timer_end && !wr && !$past(wr) |=> timer_end)
        else $error("end signal dropped without load");
    AST_IND_RUN: assert property (!sense1_indicator_pin |-> !timer_end)
        else $error("indicator lit while stopped");
    AST_TX_TAIL: assert property ($rose(timer_end) |-> ##[0:13] !ir_transmit_pin)
        else $error("transmit not released after stop");
    AST_WAKE_PULSE: assert property (halt_wake |=> !halt_wake)
        else $error("wake pulse too long");
    AST_STOP_ZERO: assert property (osc_stopped |-> timer_end)
        else $error("stop with nonzero count");
    AST_STOP_HALTED: assert property (osc_stopped |-> cpu_halted)
        else $error("stop without halt");
endmodule
bind irtc_timer irtc_timer_props u_props (.ref_clk, .resetn, .addr, .wdata, .wr, .ir_transmit_pin,
    .sense1_indicator_pin, .timer_end, .halt_wake, .osc_stopped, .osc_input_pin, .osc_output_pin, .cpu_halted);

/* bench/irtc_led_model.sv */
`timescale 1ns/100ps
// emitter and lamp: records the last finished run lengths
module irtc_led_model (
    input wire logic ref_clk,
    input wire logic ir_transmit_pin,
    input wire logic sense1_indicator_pin,
    output int hi_len,
    output int lo_len,
    output int lit_len
);
    int run = 0;
    int lit = 0;
    logic last = 1'b0;
    initial begin
        hi_len = 0;
        lo_len = 0;
        lit_len = 0;
    end
    always @(posedge ref_clk) begin
        if (ir_transmit_pin === last) run++;
        else begin
            if (last) hi_len = run;
            else lo_len = run;
            run = 1;
            last = ir_transmit_pin;
        end
        // lamp is lit while the pin is low
        if (sense1_indicator_pin === 1'b0) lit++;
        else if (lit > 0) begin
            lit_len = lit;
            lit = 0;
        end
    end
endmodule

/* bench/irtc_timer_test.sv */
`timescale 1ns/100ps
`include "irtc_params.svh"
module irtc_timer_test;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic release_in = 1'b0;
    logic [15:0] rdata;
    logic tx, ind, timer_end, halt_wake, osc_stopped, cpu_halted;
    logic [2:0] ev;
    int hi_len, lo_len, lit_len;
    int miscompares = 0;
    int n_compared = 0;
    logic [15:0] cr0_tab [5] = '{16'h1, 16'h2, 16'h3, 16'ha, 16'h8};
    int hi_tab [5] = '{4, 6, 4, 12, 1};
    int lo_tab [5] = '{4, 6, 8, 12, 1};
    assign ev = {halt_wake, osc_stopped, timer_end};
    irtc_timer u_irtc_timer (.ref_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .release_in,
        .ir_transmit_pin(tx), .sense1_indicator_pin(ind), .sense1_output_mode(1'b1), .timer_end,
        .halt_wake, .osc_stopped, .osc_input_pin(), .osc_output_pin(), .cpu_halted);
    irtc_led_model u_irtc_led_model (.ref_clk, .ir_transmit_pin(tx), .sense1_indicator_pin(ind),
        .hi_len, .lo_len, .lit_len);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
        @(posedge ref_clk);
    endtask
    task automatic wait_ev(input int i);
        for (int k = 0; k < 5000; k++) begin
            @(posedge ref_clk);
            #1;
            if (ev[i] === 1'b1) return;
        end
        miscompares++;
        end_sim();
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rchk(`IRTC_ADDR_CR0, 16'(`IRTC_CR0_RESET));
        chk({tx, ind, timer_end}, 3'b011);
        for (int i = 0; i < 2; i++) begin
            wreg(`IRTC_ADDR_CR0, i ? 16'hc : 16'h4);
            wreg(`IRTC_ADDR_TIMER, 16'h3201 + i);
            wait_ev(0);
            repeat (2) @(posedge ref_clk);
            chk(16'(hi_len), i ? 16'd48 : 16'd16);
            chk(16'(lit_len), i ? 16'd48 : 16'd16);
        end
        $display("test count done");
        wreg(`IRTC_ADDR_TIMER, 16'h3003);
        chk({tx, ind, timer_end}, 3'b010);
        wait_ev(0);
        wreg(`IRTC_ADDR_TIMER, 16'h1002);
        chk(timer_end, 1'b0);
        wait_ev(0);
        wreg(`IRTC_ADDR_TIMER, 16'h33ff);
        repeat (6) @(posedge ref_clk);
        wreg(`IRTC_ADDR_TIMER, 16'h3200);
        repeat (2) @(posedge ref_clk);
        chk(16'(hi_len), 16'd8);
        chk(timer_end, 1'b1);
        $display("test load done");
        for (int i = 0; i < 5; i++) begin
            wreg(`IRTC_ADDR_CR0, cr0_tab[i]);
            wreg(`IRTC_ADDR_TIMER, 16'h33ff);
            repeat (40) @(posedge ref_clk);
            chk(16'(hi_len), 16'(hi_tab[i]));
            chk(16'(lo_len), 16'(lo_tab[i]));
            wreg(`IRTC_ADDR_TIMER, 16'h3200);
            repeat (16) @(posedge ref_clk);
        end
        $display("test carrier done");
        wreg(`IRTC_ADDR_STATUS, 16'h0);
        wreg(`IRTC_ADDR_TIMER, 16'h3203);
        wreg(`IRTC_ADDR_STANDBY, 16'h5);
        chk(cpu_halted, 1'b1);
        wait_ev(2);
        rchk(`IRTC_ADDR_STATUS, 16'h5);
        wreg(`IRTC_ADDR_TIMER, 16'h3203);
        wreg(`IRTC_ADDR_STANDBY, 16'h5);
        chk(cpu_halted, 1'b0);
        wait_ev(0);
        wreg(`IRTC_ADDR_STATUS, 16'h0);
        wreg(`IRTC_ADDR_STANDBY, 16'h5);
        chk(cpu_halted, 1'b0);
        rchk(`IRTC_ADDR_STATUS, 16'h5);
        $display("test halt done");
        for (int i = 0; i < 2; i++) begin
            wreg(`IRTC_ADDR_STATUS, 16'h0);
            wreg(`IRTC_ADDR_TIMER, 16'h3203);
            wreg(`IRTC_ADDR_STANDBY, i ? 16'h8 : 16'h0);
            wait_ev(i ? 0 : 1);
            chk({timer_end, cpu_halted}, 2'b11);
            release_in <= 1'b1;
            wait_ev(2);
            release_in <= 1'b0;
            rchk(`IRTC_ADDR_STATUS, 16'h5);
        end
        $display("test standby done");
        end_sim();
    end
endmodule
